// >>> core/crb_receive.sv
// CAN receive buffering: assembly buffer, two filtered slots, flags and pins
`timescale 1ns/1ps
`default_nettype none

module crb_receive (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    input  wire logic                  reg_we,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic [7:0]            reg_wmask,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  mab_we,
    input  wire logic [10:0]           mab_sid,
    input  wire logic [17:0]           mab_eid,
    input  wire logic                  mab_ext,
    input  wire logic                  mab_rtr,
    input  wire logic [3:0]            mab_dlc,
    input  wire logic [63:0]           mab_data,
    input  wire logic                  frame_ok,
    input  wire logic                  frame_err,
    input  wire logic [5:0][28:0]      filter_value,
    input  wire logic [5:0]            filter_wide_id_select,
    input  wire logic [1:0][28:0]      mask_value,
    input  wire logic                  bus_receive_input,
    input  wire logic                  bus_idle,
    input  wire logic                  sample_point,
    output logic                       sof_pulse,
    output logic                       sof_glitch,
    output logic                       alert_n,
    output logic      [1:0]            full_pin_o,
    output logic      [1:0]            full_pin_oe
);

    // Frame images: assembly buffer and the two receive slots
    logic [12:0][7:0] mab_q;           // Assembly buffer bytes
    logic [12:0][7:0] slot0_q;         // Primary slot bytes
    logic [12:0][7:0] slot1_q;         // Secondary slot bytes
    // Control and status state
    logic [1:0]       mode_q [2];      // Filter mode per slot
    logic             roll_q;          // Rollover enable
    logic [1:0]       rtr_q;           // Remote request seen per slot
    logic             hit0_q;          // Primary filter hit
    logic [2:0]       hit1_q;          // Secondary filter hit
    logic [1:0]       flag_q;          // Received flags
    logic [1:0]       flag_d;
    logic [1:0]       inten_q;         // Received interrupt enables
    logic [1:0]       ovf_q;           // Overflow flags
    logic [1:0]       ovf_d;
    logic [5:0]       pin_ctrl_q;      // Full pin control bits
    logic             sof_en_q;        // Start-of-frame detector enable
    logic [7:0]       tx_byte_q;       // Transmit payload byte
    logic [7:0]       rd_d;
    logic [7:0]       ctrl0_wr;        // Primary control byte after a masked write
    logic [7:0]       ctrl1_wr;        // Secondary control byte after a masked write
    logic [7:0]       sof_wr;          // Start-of-frame control after a masked write
    // Decoded frame fields from the assembly buffer
    logic [10:0]      frm_sid;
    logic [17:0]      frm_eid;
    logic             frm_ext;
    logic             frm_rtr;
    logic [28:0]      frm_id;
    logic [28:0]      cmp_mask;        // Standard frames compare only identifier top
    logic [5:0]       match;           // Per-filter hit
    logic             acc0;
    logic             acc1;
    logic             hit0;
    logic [2:0]       hit1;
    logic             frame_end;
    logic             load0;
    logic             load1;
    logic             roll_go;
    logic             wr;
    logic [3:0]       idx;
    // Start-of-frame detector
    crb_pkg::crb_sof_state_type sof_state_q;
    logic              rx_prev_q;       // Previous bus level, 1 = recessive

    assign wr = ce && reg_we;

    // Masked merge: plain writes use an all-ones mask
    function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic [7:0] msk);
        merge8 = (old_v & ~msk) | (new_v & msk);
    endfunction

    // Merged control bytes, so that single fields can be picked out of them
    always_comb
    begin
        ctrl0_wr = merge8({1'b0, mode_q[0], 2'b00, roll_q, 2'b00}, reg_wdata, reg_wmask);
        ctrl1_wr = merge8({1'b0, mode_q[1], 5'h00}, reg_wdata, reg_wmask);
        sof_wr   = merge8({7'h00, sof_en_q}, reg_wdata, reg_wmask);
    end

    // Assembly buffer takes every frame the engine builds, accepted or not
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mab_q <= '0;
        else if (ce && mab_we)
        begin
            mab_q[0]  <= mab_sid[10:3];
            mab_q[1]  <= {mab_sid[2:0], mab_rtr & ~mab_ext, mab_ext, 1'b0, mab_eid[17:16]};
            mab_q[2]  <= mab_eid[15:8];
            mab_q[3]  <= mab_eid[7:0];
            mab_q[4]  <= {1'b0, mab_rtr & mab_ext, 2'b00, mab_dlc};
            for (int i = 0; i < 8; i++)
                mab_q[5 + i] <= mab_data[8 * i +: 8];
        end
    end

    // Frame fields as seen by the filters
    always_comb
    begin
        frm_sid  = {mab_q[0], mab_q[1][7:5]};
        frm_ext  = mab_q[1][3];
        frm_eid  = {mab_q[1][1:0], mab_q[2], mab_q[3]};
        frm_rtr  = frm_ext ? mab_q[4][6] : mab_q[1][4];
        frm_id   = {frm_sid, frm_ext ? frm_eid : 18'h00000};
        cmp_mask = frm_ext ? 29'h1FFFFFFF : 29'h1FFC0000;
    end

    // One comparator per filter; first two belong to the primary slot
    for (genvar g = 0; g < crb_pkg::NUM_FILTERS; g++)
    begin : g_filt
        localparam int S = (g < crb_pkg::SLOT0_FILTERS) ? 0 : 1;
        logic type_ok;
        always_comb
        begin
            // Filter kind must equal frame kind; modes 01/10 kill the wrong kind
            type_ok = (filter_wide_id_select[g] == frm_ext)
                && !(mode_q[S] == crb_pkg::MODE_STD_ONLY && frm_ext)
                && !(mode_q[S] == crb_pkg::MODE_EXT_ONLY && !frm_ext);
            match[g] = type_ok
                && (((frm_id ^ filter_value[g]) & mask_value[S] & cmp_mask) == 29'h0);
        end
    end

    // Acceptance and destination; primary slot is decided first
    always_comb
    begin
        frame_end = ce && (frame_ok || frame_err);
        hit0      = !match[0];
        hit1      = 3'h0;
        for (int f = crb_pkg::NUM_FILTERS - 1; f >= crb_pkg::SLOT0_FILTERS; f--)
            if (match[f])
                hit1 = 3'(f);
        if (frame_ok)
        begin
            acc0 = (mode_q[0] == crb_pkg::MODE_ACCEPT_ALL) || (|match[1:0]);
            acc1 = (mode_q[1] == crb_pkg::MODE_ACCEPT_ALL) || (|match[5:2]);
        end
        else
        begin
            // Errored frame only reaches a slot that accepts everything
            acc0 = (mode_q[0] == crb_pkg::MODE_ACCEPT_ALL);
            acc1 = (mode_q[1] == crb_pkg::MODE_ACCEPT_ALL);
        end
        load0   = frame_end && acc0 && !flag_q[0];
        roll_go = frame_end && acc0 && flag_q[0] && roll_q;
        load1   = (roll_go || (frame_end && !acc0 && acc1)) && !flag_q[1];
    end

    // Slot images overwritten whole from the assembly buffer
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            slot0_q <= '0;
            slot1_q <= '0;
        end
        else
        begin
            if (load0)
                slot0_q <= mab_q;
            if (load1)
                slot1_q <= mab_q;
        end
    end

    // Filter hit and remote bits refreshed on each load
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rtr_q  <= crb_pkg::RST_PAIR;
            hit0_q <= 1'b0;
            hit1_q <= 3'h0;
        end
        else
        begin
            if (load0)
            begin
                rtr_q[0] <= frm_rtr;
                hit0_q   <= hit0;
            end
            if (load1)
            begin
                rtr_q[1] <= frm_rtr;
                // After rollover the hit names the primary filter that took it
                hit1_q   <= roll_go ? {2'b00, hit0} : hit1;
            end
        end
    end

    // Received flags: a load in the clearing cycle still sets the flag
    always_comb
    begin
        flag_d = flag_q;
        if (wr && reg_addr == crb_pkg::ADDR_INT_FLAG)
            flag_d = 2'(merge8({6'h00, flag_q}, reg_wdata, reg_wmask));
        flag_d = flag_d | {load1, load0};
    end

    // Overflow: slot busy and no rollover route, frame dropped
    always_comb
    begin
        ovf_d = ovf_q;
        if (wr && reg_addr == crb_pkg::ADDR_OVERFLOW)
            ovf_d = 2'(merge8({6'h00, ovf_q}, reg_wdata, reg_wmask));
        ovf_d[0] = ovf_d[0] | (frame_end && acc0 && flag_q[0] && !roll_q);
        ovf_d[1] = ovf_d[1] | ((roll_go || (frame_end && !acc0 && acc1)) && flag_q[1]);
    end

    // Flag and overflow registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            flag_q <= crb_pkg::RST_PAIR;
            ovf_q  <= crb_pkg::RST_PAIR;
        end
        else if (ce)
        begin
            flag_q <= flag_d;
            ovf_q  <= ovf_d;
        end
    end

    // Software-written configuration
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode_q[0]  <= crb_pkg::MODE_FILTERED;
            mode_q[1]  <= crb_pkg::MODE_FILTERED;
            roll_q     <= 1'b0;
            inten_q    <= crb_pkg::RST_PAIR;
            pin_ctrl_q <= crb_pkg::RST_PIN_CTRL;
            sof_en_q   <= 1'b0;
            tx_byte_q  <= crb_pkg::RST_BYTE;
        end
        else if (wr)
        begin
            unique case (reg_addr)
                crb_pkg::ADDR_SLOT0_CTRL:
                begin
                    mode_q[0] <= ctrl0_wr[crb_pkg::MODE_LSB +: 2];
                    roll_q    <= ctrl0_wr[crb_pkg::ROLL_BIT];
                end
                crb_pkg::ADDR_SLOT1_CTRL:
                    mode_q[1] <= ctrl1_wr[crb_pkg::MODE_LSB +: 2];
                crb_pkg::ADDR_INT_ENABLE:
                    inten_q <= 2'(merge8({6'h00, inten_q}, reg_wdata, reg_wmask));
                // Masked write lets software move one level bit without disturbing the other
                crb_pkg::ADDR_PIN_CTRL:
                    pin_ctrl_q <= 6'(merge8({2'b00, pin_ctrl_q}, reg_wdata, reg_wmask));
                crb_pkg::ADDR_SOF_CTRL:
                    sof_en_q <= sof_wr[0];
                crb_pkg::ADDR_TX_PAYLOAD:
                    tx_byte_q <= merge8(tx_byte_q, reg_wdata, reg_wmask);
                default:
                    ;
            endcase
        end
    end

    // Read data, registered; unmapped addresses read zero
    always_comb
    begin
        idx  = reg_addr[3:0] - crb_pkg::SLOT_FIRST_IDX;
        rd_d = 8'h00;
        unique case (reg_addr)
            crb_pkg::ADDR_SLOT0_CTRL:
                rd_d = {1'b0, mode_q[0], 1'b0, rtr_q[0], roll_q, roll_q, hit0_q};
            crb_pkg::ADDR_SLOT1_CTRL:
                rd_d = {1'b0, mode_q[1], 1'b0, rtr_q[1], hit1_q};
            crb_pkg::ADDR_INT_ENABLE: rd_d = {6'h00, inten_q};
            crb_pkg::ADDR_INT_FLAG:   rd_d = {6'h00, flag_q};
            crb_pkg::ADDR_OVERFLOW:   rd_d = {6'h00, ovf_q};
            crb_pkg::ADDR_PIN_CTRL:   rd_d = {2'b00, pin_ctrl_q};
            crb_pkg::ADDR_SOF_CTRL:   rd_d = {7'h00, sof_en_q};
            crb_pkg::ADDR_TX_PAYLOAD: rd_d = tx_byte_q;
            default:
            begin
                if (reg_addr[3:0] >= crb_pkg::SLOT_FIRST_IDX
                    && reg_addr[3:0] <= crb_pkg::SLOT_LAST_IDX)
                begin
                    if (reg_addr[7:4] == crb_pkg::ADDR_SLOT0_CTRL[7:4])
                        rd_d = slot0_q[idx];
                    else if (reg_addr[7:4] == crb_pkg::ADDR_SLOT1_CTRL[7:4])
                        rd_d = slot1_q[idx];
                end
            end
        endcase
    end
    // Read register and alert pin
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_rdata <= crb_pkg::RST_BYTE;
            alert_n   <= 1'b1;
        end
        else if (ce)
        begin
            reg_rdata <= rd_d;
            alert_n   <= !(|(flag_d & inten_q));
        end
    end

    // Full pins: undriven, flag follower, or plain output
    for (genvar p = 0; p < 2; p++)
    begin : g_pin
        always_ff @(posedge clk)
        begin
            if (sys_rst)
            begin
                full_pin_oe[p] <= 1'b0;
                full_pin_o[p]  <= 1'b1;
            end
            else if (ce)
            begin
                full_pin_oe[p] <= pin_ctrl_q[crb_pkg::PIN_EN_LSB + p];
                if (pin_ctrl_q[crb_pkg::PIN_MODE_LSB + p])
                    full_pin_o[p] <= !flag_d[p];
                else
                    full_pin_o[p] <= pin_ctrl_q[crb_pkg::PIN_LEVEL_LSB + p];
            end
        end
    end

    // Start-of-frame detector: arm on idle falling edge, confirm at sample point
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sof_state_q <= crb_pkg::SOF_IDLE;
            rx_prev_q   <= 1'b1;
            sof_pulse   <= 1'b0;
            sof_glitch  <= 1'b0;
        end
        else if (ce)
        begin
            rx_prev_q  <= bus_receive_input;
            sof_pulse  <= 1'b0;
            sof_glitch <= 1'b0;
            unique case (sof_state_q)
                crb_pkg::SOF_IDLE:
                    if (sof_en_q && bus_idle && rx_prev_q && !bus_receive_input)
                        sof_state_q <= crb_pkg::SOF_ARMED;
                crb_pkg::SOF_ARMED:
                    if (bus_receive_input)
                    begin
                        // Recessive again before sampling: treat as glitch
                        sof_glitch  <= 1'b1;
                        sof_state_q <= crb_pkg::SOF_IDLE;
                    end
                    else if (sample_point)
                    begin
                        sof_pulse   <= 1'b1;
                        sof_state_q <= crb_pkg::SOF_IDLE;
                    end
            endcase
        end
    end

    // Checks on the logic above
    sequence s_armed_low_sample;
        sof_state_q == crb_pkg::SOF_ARMED && ce && !bus_receive_input && sample_point;
    endsequence
    sequence s_armed_glitch;
        sof_state_q == crb_pkg::SOF_ARMED && ce && bus_receive_input;
    endsequence

    a_lockout_hold: assert property (@(posedge clk) disable iff (sys_rst)
        flag_q[0] |=> $stable(slot0_q))
        else $error("primary slot changed while flagged");
    a_load_flag: assert property (@(posedge clk) disable iff (sys_rst)
        load1 |=> flag_q[1] && slot1_q == $past(mab_q))
        else $error("secondary load did not set flag or copy");
    a_copy_whole: assert property (@(posedge clk) disable iff (sys_rst)
        load0 |=> slot0_q == $past(mab_q) && flag_q[0])
        else $error("primary slot not overwritten whole");
    a_alert_low: assert property (@(posedge clk) disable iff (sys_rst)
        // A host clear in the same cycle legally releases the pin
        (ce && |(flag_q & inten_q) && !(wr && reg_addr == crb_pkg::ADDR_INT_FLAG))
        |=> !alert_n)
        else $error("alert not low with enabled flag");
    a_primary_first: assert property (@(posedge clk) disable iff (sys_rst)
        (frame_end && acc0 && !flag_q[0]) |-> load0 && !load1)
        else $error("primary slot lost priority");
    a_rollover_go: assert property (@(posedge clk) disable iff (sys_rst)
        (frame_end && acc0 && flag_q[0] && roll_q && !flag_q[1])
        |-> load1 ##1 hit1_q[2:1] == 2'b00)
        else $error("rollover did not reach secondary slot");
    a_accept_all: assert property (@(posedge clk) disable iff (sys_rst)
        (frame_end && mode_q[0] == crb_pkg::MODE_ACCEPT_ALL && !flag_q[0]) |-> load0)
        else $error("accept-all mode dropped a frame");
    a_overflow_set: assert property (@(posedge clk) disable iff (sys_rst)
        (frame_end && acc0 && flag_q[0] && !roll_q) |=> ovf_q[0] && $stable(slot0_q))
        else $error("busy primary slot did not flag overflow");
    a_sof_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        s_armed_low_sample |=> sof_pulse ##1 !sof_pulse)
        else $error("start-of-frame pulse missing or long");
    a_sof_glitch: assert property (@(posedge clk) disable iff (sys_rst)
        s_armed_glitch |=> !sof_pulse && sof_glitch)
        else $error("glitch produced start-of-frame");
    a_pin_hiz: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && !pin_ctrl_q[crb_pkg::PIN_EN_LSB]) |=> !full_pin_oe[0])
        else $error("disabled full pin is driven");
    a_pin_track: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && pin_ctrl_q[crb_pkg::PIN_MODE_LSB + 1] && flag_d[1]) |=> !full_pin_o[1])
        else $error("full pin not low with flag set");

endmodule

`default_nettype wire

// >>> core/crb_pkg.sv
// Constants shared by the CAN receive buffering block
package crb_pkg;
    // Register offsets on the host register port
    localparam logic [7:0] ADDR_TX_PAYLOAD  = 8'h36; // Transmit payload byte storage
    localparam logic [7:0] ADDR_PIN_CTRL    = 8'h0C; // Full pin control register
    localparam logic [7:0] ADDR_SOF_CTRL    = 8'h0E; // Start-of-frame control
    localparam logic [7:0] ADDR_INT_ENABLE  = 8'h2B; // Interrupt enable register
    localparam logic [7:0] ADDR_INT_FLAG    = 8'h2C; // Interrupt flag register
    localparam logic [7:0] ADDR_OVERFLOW    = 8'h2D; // Receive overflow flags
    localparam logic [7:0] ADDR_SLOT0_CTRL  = 8'h60; // Primary slot control
    localparam logic [7:0] ADDR_SLOT1_CTRL  = 8'h70; // Secondary slot control
    // Slot image: control byte at base, frame bytes at base+1 to base+13
    localparam int         SLOT_BYTES       = 13;
    localparam logic [3:0] SLOT_FIRST_IDX   = 4'h1;
    localparam logic [3:0] SLOT_LAST_IDX    = 4'hD;
    // Slot control field positions
    localparam int         MODE_LSB         = 5;
    localparam int         RTR_BIT          = 3;
    localparam int         ROLL_BIT         = 2;
    localparam int         ROLL_COPY_BIT    = 1;
    // Full pin control field positions (pin index added)
    localparam int         PIN_MODE_LSB     = 0;
    localparam int         PIN_EN_LSB       = 2;
    localparam int         PIN_LEVEL_LSB    = 4;
    // Filter modes
    localparam logic [1:0] MODE_FILTERED    = 2'h0;
    localparam logic [1:0] MODE_STD_ONLY    = 2'h1;
    localparam logic [1:0] MODE_EXT_ONLY    = 2'h2;
    localparam logic [1:0] MODE_ACCEPT_ALL  = 2'h3;
    // Reset values
    localparam logic [7:0] RST_BYTE         = 8'h00;
    localparam logic [1:0] RST_PAIR         = 2'h0;
    localparam logic [5:0] RST_PIN_CTRL     = 6'h00;
    // Filter count and slot ownership
    localparam int         NUM_FILTERS      = 6;
    localparam int         SLOT0_FILTERS    = 2;
    // Start-of-frame detector states
    typedef enum logic [0:0] {
        SOF_IDLE  = 1'b0,
        SOF_ARMED = 1'b1
    } crb_sof_state_type;
endpackage

// >>> sim/crb_engine_model.sv
// Protocol engine and bus model that feeds the receive block
`timescale 1ns/1ps
`default_nettype none
module crb_engine_model (
    input  wire logic        clk,
    output logic             mab_we,
    output logic [10:0]      mab_sid,
    output logic [17:0]      mab_eid,
    output logic             mab_ext,
    output logic             mab_rtr,
    output logic [3:0]       mab_dlc,
    output logic [63:0]      mab_data,
    output logic             frame_ok,
    output logic             frame_err,
    output logic             bus_receive_input,
    output logic             bus_idle,
    output logic             sample_point
);
    // Quiet, recessive and idle bus at time zero
    initial
    begin
        {mab_we, frame_ok, frame_err, sample_point, mab_rtr} = 5'h00;
        {mab_sid, mab_eid, mab_ext, mab_dlc, mab_data} = '0;
        bus_receive_input = 1'b1;
        bus_idle = 1'b1;
    end
    // Assemble one frame, end it a cycle later; err takes the abort path
    task automatic send(input logic [10:0] sid, input logic ext, input logic [63:0] d,
                        input logic err);
        @(posedge clk);
        mab_we <= 1'b1;
        {mab_sid, mab_ext, mab_data, mab_eid, mab_dlc} <= {sid, ext, d, d[17:0], 4'h8};
        @(posedge clk);
        mab_we <= 1'b0;
        frame_ok <= !err;
        frame_err <= err;
        @(posedge clk);
        frame_ok <= 1'b0;
        frame_err <= 1'b0;
    endtask
    // Falling edge on the idle bus; without hold the dominant ends before the sample point
    task automatic sof(input logic hold);
        @(posedge clk);
        bus_receive_input <= 1'b0;
        repeat (2) @(posedge clk);
        bus_receive_input <= hold ? 1'b0 : 1'b1;
        @(posedge clk);
        sample_point <= 1'b1;
        @(posedge clk);
        sample_point <= 1'b0;
        bus_receive_input <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the receive buffering block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic            clk = 1'b0;       // 40 MHz
    logic            sys_rst = 1'b1;   // Held for 12 cycles
    logic            reg_we = 1'b0;
    logic [7:0]      reg_addr = 8'h00, reg_wdata = 8'h00, reg_wmask = 8'h00, reg_rdata;
    logic            mab_we, mab_ext, mab_rtr, frame_ok, frame_err;
    logic [10:0]     mab_sid, sid;
    logic [17:0]     mab_eid;
    logic [3:0]      mab_dlc;
    logic [63:0]     mab_data, d;
    logic            rx, idle, spt, sof_pulse, sof_glitch, alert_n;
    logic [5:0][28:0] fv = '0;         // Filter values
    logic [5:0]      fsel = 6'h00;     // Filter identifier kind
    logic [1:0][28:0] mv = '1;         // Masks compare every bit
    logic [1:0]      pin_o, pin_oe;
    logic [7:0]      pv[5] = '{8'h00, 8'h04, 8'h14, 8'h0F, 8'h2D}; // Pin setups
    int              miscompares = 0, n_tests = 0, n_sof = 0, n_gl = 0, cyc = 0, i;
    int              seed = 32'h59fd;
    always #12.5 clk = ~clk;
    crb_receive crb_receive_inst (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask),
        .reg_rdata(reg_rdata), .mab_we(mab_we), .mab_sid(mab_sid), .mab_eid(mab_eid),
        .mab_ext(mab_ext), .mab_rtr(mab_rtr), .mab_dlc(mab_dlc), .mab_data(mab_data),
        .frame_ok(frame_ok), .frame_err(frame_err), .filter_value(fv),
        .filter_wide_id_select(fsel), .mask_value(mv), .bus_receive_input(rx),
        .bus_idle(idle), .sample_point(spt), .sof_pulse(sof_pulse), .sof_glitch(sof_glitch),
        .alert_n(alert_n), .full_pin_o(pin_o), .full_pin_oe(pin_oe));
    crb_engine_model crb_engine_model_inst (.clk(clk), .mab_we(mab_we), .mab_sid(mab_sid),
        .mab_eid(mab_eid), .mab_ext(mab_ext), .mab_rtr(mab_rtr), .mab_dlc(mab_dlc),
        .mab_data(mab_data), .frame_ok(frame_ok), .frame_err(frame_err),
        .bus_receive_input(rx), .bus_idle(idle), .sample_point(spt));
    // Count start pulses and glitch reports; cut a hang short
    always @(posedge clk)
    begin
        n_sof += (sof_pulse === 1'b1);
        n_gl += (sof_glitch === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One register write; mask gives the bit-modify form
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        @(posedge clk);
        {reg_we, reg_addr, reg_wdata, reg_wmask} <= {1'b1, a, v, m};
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    // Read data is registered, so it lands one edge after the address; the check waits two
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 chk(reg_rdata, exp);
    endtask
    // Expected {oe, level} of a full pin from its control bits and flag
    function automatic logic [1:0] pin_exp(input logic [7:0] c, input logic flag);
        if (!c[2]) return 2'b01;
        return c[0] ? {1'b1, !flag} : {1'b1, c[4]};
    endfunction
    // Level seen on a full pin: a released pin floats up to its pull-up
    function automatic logic [7:0] seen(input logic oe, input logic o);
        return {6'h00, oe, oe ? o : 1'b1};
    endfunction
    task automatic frame(input logic ext, input logic err);
        sid = $random(seed);
        d = {$random(seed), $random(seed)};
        crb_engine_model_inst.send(sid, ext, d, err);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        rc(8'h2C, 8'h00);
        wr(8'h2B, 8'h03, 8'hFF);
        wr(8'h60, 8'h60, 8'hFF);
        wr(8'h0C, 8'h05, 8'hFF);
        frame(1'b0, 1'b0);
        rc(8'h2C, 8'h01);
        chk({7'h00, alert_n}, 8'h00);
        chk({6'h00, pin_oe[0], pin_o[0]}, 8'h02);
        rc(8'h61, sid[10:3]);
        for (i = 0; i < 8; i++) rc(8'h66 + i[7:0], d[8*i+:8]);
        $display("accept-all load done");
        frame(1'b0, 1'b0);
        rc(8'h2D, 8'h01);
        wr(8'h60, 8'h64, 8'hFF);
        frame(1'b0, 1'b0);
        rc(8'h2C, 8'h03);
        rc(8'h71, sid[10:3]);
        wr(8'h2C, 8'h00, 8'h03);
        wr(8'h2D, 8'h00, 8'hFF);
        chk({6'h00, alert_n, pin_o[0]}, 8'h03);
        $display("overflow and rollover done");
        wr(8'h60, 8'h00, 8'hFF);
        sid = $random(seed);
        for (i = 0; i < 5; i++) fv[i] = {~sid, 18'h00000};
        fv[5] = {sid, 18'h00000};
        crb_engine_model_inst.send(sid, 1'b0, d, 1'b0);
        rc(8'h2C, 8'h02);
        rc(8'h70, 8'h05);
        fv[0] = {sid, 18'h00000};
        wr(8'h2C, 8'h00, 8'h03);
        crb_engine_model_inst.send(sid, 1'b0, d, 1'b0);
        rc(8'h2C, 8'h01);
        wr(8'h2C, 8'h00, 8'h03);
        wr(8'h70, 8'h20, 8'hFF);
        fsel <= 6'h20;                              // Filter 5 now wants extended frames
        fv[5] <= {sid, d[17:0]};
        crb_engine_model_inst.send(sid, 1'b1, d, 1'b0);
        rc(8'h2C, 8'h00);
        wr(8'h70, 8'h40, 8'hFF);
        crb_engine_model_inst.send(sid, 1'b1, d, 1'b0);
        rc(8'h2C, 8'h02);
        rc(8'h70, 8'h45);
        $display("filter modes done");
        wr(8'h60, 8'h60, 8'hFF);
        frame(1'b0, 1'b1);
        rc(8'h2C, 8'h03);
        rc(8'h61, sid[10:3]);
        for (i = 0; i < 5; i++)
        begin
            wr(8'h0C, pv[i], 8'h3F);
            repeat (2) @(posedge clk);
            chk(seen(pin_oe[0], pin_o[0]), {6'h00, pin_exp(pv[i], 1'b1)});
            chk(seen(pin_oe[1], pin_o[1]), {6'h00, pin_exp(pv[i] >> 1, 1'b1)});
        end
        $display("full pins done");
        wr(8'h0E, 8'h01, 8'hFF);
        crb_engine_model_inst.sof(1'b1);
        repeat (3) @(posedge clk);
        chk(n_sof[7:0], 8'h01);
        crb_engine_model_inst.sof(1'b0);
        repeat (3) @(posedge clk);
        chk({n_sof[3:0], n_gl[3:0]}, 8'h11);
        $display("start of frame done");
        finish_test();
    end
endmodule
`default_nettype wire
